// ---- bps_byte_port.sv ----
// Byte port with control pins and parallel slave mode
//
// Contract
// - Data pins are general I/O or slave bus bits per slave select.
// - Three control pins, each direction set by its own bit.
// - Slave select makes control pins read strobe, store strobe, select.
// - Control pin configured analog reads zero.
// - Control direction bits act even on analog pins.
// - After reset control pins are analog and read zero.
// - Input-full is bit 7, read-only, reset zero, set while byte waits.
// - Output-full read-only, reset zero, set until external read.
// - Overflow sets on write while input unread; software clears it.
// - Slave select bit 4 chooses slave mode, read/write, reset zero.
// - Status bit 3 reads zero.
// - Low three status bits are pin directions, one input, reset one.
// - Read strobe low with select drives output latch onto data pins.
// - Store strobe low with select captures data pins.
// - Select high makes both strobes ignored.
// - Slave mode keeps separate input and output latches; direction ignored.
// - Store strobe end latches data, sets input-full and event; read clears.
// - Output-full clears at external read start until firmware write.
// - Outside slave mode both full flags zero, overflow kept.
`timescale 1ns/1ps
module bps_byte_port #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Data pins
  input  wire logic [7:0]        data_pin_in,
  output logic [7:0]             data_pin_out,
  output logic [7:0]             data_pin_oe_n,
  // Control pins: 0 read strobe, 1 store strobe, 2 select
  input  wire logic [2:0]        ctrl_pin_in,
  output logic [2:0]             ctrl_pin_out,
  output logic [2:0]             ctrl_pin_oe_n,
  // Transfer complete event
  output logic                   slave_port_irq_flag
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Narrower buses cannot reach the upper register indices
  if (ADDR_W < 10) begin : g_addr_w_check
    $error("ADDR_W must be at least 10");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    // Software registers and latches
    logic [7:0] out_latch;
    logic [7:0] in_latch;
    logic [7:0] capture;
    logic [7:0] data_dir;
    logic [2:0] ctrl_dir;
    logic [2:0] ctrl_latch;
    logic [2:0] analog_cfg;
    logic       slave_mode;
    // Slave port flags
    logic       in_full;
    logic       out_full;
    logic       overflow;
    // Strobe history and event
    logic       store_prev;
    logic       read_prev;
    logic       event_pulse;
    // Pin drivers
    logic [7:0] d_out;
    logic [7:0] d_oe_n;
    logic [2:0] c_out;
    logic [2:0] c_oe_n;
  } bps_st_t;

  bps_st_t s;
  bps_st_t next_s;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  // Write side
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_ok;
  // Read side
  logic       rd_en;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic       rd_ok;

  bps_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clock         (clock),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_idx        (wr_idx),
    .wr_data       (wr_data),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic known_idx(input logic [7:0] idx);
    known_idx = (idx == bps_pkg::IDX_DATA_PORT)   ||
                (idx == bps_pkg::IDX_CTRL_PORT)   ||
                (idx == bps_pkg::IDX_DATA_DIR)    ||
                (idx == bps_pkg::IDX_CTRL_DIR_ST) ||
                (idx == bps_pkg::IDX_ANALOG_CFG);
  endfunction : known_idx

  logic       pins_digital;
  logic [2:0] ctrl_read;
  logic       sel_active;
  logic       store_active;
  logic       read_active;
  logic       store_done;
  logic       read_done;
  logic       wr_go;
  logic       rd_data_port;

  always_comb begin
    // Reset value of the select field leaves all three pins analog
    pins_digital = ((s.analog_cfg & bps_pkg::DIGITAL_CFG_MASK) == bps_pkg::DIGITAL_CFG_MASK);
    ctrl_read    = pins_digital ? ctrl_pin_in : 3'h0;
  end

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  always_comb begin
    sel_active   = s.slave_mode & ~ctrl_pin_in[bps_pkg::PIN_SELECT];
    store_active = sel_active & ~ctrl_pin_in[bps_pkg::PIN_STORE];
    read_active  = sel_active & ~ctrl_pin_in[bps_pkg::PIN_READ];
    store_done   = s.store_prev & ~store_active & s.slave_mode;
    read_done    = s.read_prev & ~read_active & s.slave_mode;
  end

  // ----------------------------------------
  // Register access strobes
  // ----------------------------------------
  always_comb begin
    // Front end already drops writes without byte lane 0
    wr_go        = wr_en;
    rd_data_port = rd_en & (rd_idx == bps_pkg::IDX_DATA_PORT);
  end

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb begin
    rd_ok   = known_idx(rd_idx);
    rd_data = 8'h00;
    case (rd_idx)
      bps_pkg::IDX_DATA_PORT: begin
        // Slave mode reads the input latch, otherwise the pins
        rd_data = s.slave_mode ? s.in_latch : data_pin_in;
      end
      bps_pkg::IDX_CTRL_PORT: begin
        rd_data = {5'h00, ctrl_read};
      end
      bps_pkg::IDX_DATA_DIR: begin
        rd_data = s.data_dir;
      end
      bps_pkg::IDX_CTRL_DIR_ST: begin
        rd_data = {s.in_full,
                   s.out_full,
                   s.overflow,
                   s.slave_mode,
                   1'b0,
                   s.ctrl_dir};
      end
      bps_pkg::IDX_ANALOG_CFG: begin
        rd_data = {5'h00, s.analog_cfg};
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  assign wr_ok = known_idx(wr_idx);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.store_prev  = store_active;
    next_s.read_prev   = read_active;
    next_s.event_pulse = store_done | read_done;

    if (store_active) begin
      next_s.capture = data_pin_in;
    end

    // Software writes
    if (wr_go) begin
      case (wr_idx)
        bps_pkg::IDX_DATA_PORT: begin
          next_s.out_latch = wr_data;
          // A write during an external read stays unflagged
          if (s.slave_mode & ~read_active) begin
            next_s.out_full = 1'b1;
          end
        end
        bps_pkg::IDX_CTRL_PORT: begin
          next_s.ctrl_latch = wr_data[2:0];
        end
        bps_pkg::IDX_DATA_DIR: begin
          next_s.data_dir = wr_data;
        end
        bps_pkg::IDX_CTRL_DIR_ST: begin
          // Both full flags are read-only; they keep their value unless this write clears slave mode
          next_s.overflow   = wr_data[bps_pkg::BIT_OVERFLOW];
          next_s.slave_mode = wr_data[bps_pkg::BIT_SLAVE];
          next_s.ctrl_dir   = wr_data[bps_pkg::BIT_CDIR_HI:0];
        end
        bps_pkg::IDX_ANALOG_CFG: begin
          next_s.analog_cfg = wr_data[2:0];
        end
        default: begin
        end
      endcase
    end

    // Firmware read of the input latch frees it
    if (rd_data_port & s.slave_mode) begin
      next_s.in_full = 1'b0;
    end

    // External read start empties the output buffer
    if (read_active) begin
      next_s.out_full = 1'b0;
    end

    // Hardware sets win over software clears
    if (store_done) begin
      next_s.in_latch = s.capture;
      next_s.in_full  = 1'b1;
      if (s.in_full) begin
        next_s.overflow = 1'b1;
      end
    end

    if (!next_s.slave_mode) begin
      next_s.in_full  = 1'b0;
      next_s.out_full = 1'b0;
    end

    // Pin drivers
    next_s.d_out  = next_s.out_latch;
    if (next_s.slave_mode) begin
      // The host strobe steers the data pins; direction bits are ignored
      next_s.d_oe_n = {8{~read_active}};
    end else begin
      next_s.d_oe_n = next_s.data_dir;
    end
    next_s.c_out  = next_s.ctrl_latch;
    // Direction bits steer drivers even for analog pins
    next_s.c_oe_n = next_s.ctrl_dir;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Pins come up released so nothing drives before software sets a direction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s            <= '0;
      s.out_latch  <= bps_pkg::RST_LATCH;
      s.in_latch   <= bps_pkg::RST_LATCH;
      s.data_dir   <= bps_pkg::RST_DATA_DIR;
      s.ctrl_dir   <= bps_pkg::RST_CTRL_DIR;
      s.analog_cfg <= bps_pkg::RST_ANALOG_CFG;
      s.d_oe_n     <= bps_pkg::RST_DATA_DIR;
      s.c_oe_n     <= bps_pkg::RST_CTRL_DIR;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flop of the state record, with no logic after it
  assign data_pin_out        = s.d_out;
  assign data_pin_oe_n       = s.d_oe_n;
  assign ctrl_pin_out        = s.c_out;
  assign ctrl_pin_oe_n       = s.c_oe_n;
  assign slave_port_irq_flag = s.event_pulse;

endmodule : bps_byte_port

// ---- bps_pkg.sv ----
// Constants shared by the byte port block
package bps_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_DATA_PORT   = 8'h08;
  localparam logic [7:0] IDX_CTRL_PORT   = 8'h09;
  localparam logic [7:0] IDX_DATA_DIR    = 8'h88;
  localparam logic [7:0] IDX_CTRL_DIR_ST = 8'h89;
  localparam logic [7:0] IDX_ANALOG_CFG  = 8'h9F;

  // ----------------------------------------
  // Field positions of control_direction_status
  // ----------------------------------------
  localparam int BIT_IN_FULL  = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_OVERFLOW = 5;
  localparam int BIT_SLAVE    = 4;
  localparam int BIT_CDIR_HI  = 2;

  // ----------------------------------------
  // Control pin positions
  // ----------------------------------------
  localparam int PIN_READ   = 0;
  localparam int PIN_STORE  = 1;
  localparam int PIN_SELECT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_DATA_DIR   = 8'hFF;
  localparam logic [2:0] RST_CTRL_DIR   = 3'h7;
  localparam logic [2:0] RST_ANALOG_CFG = 3'h0;
  localparam logic [7:0] RST_LATCH      = 8'h00;

  // ----------------------------------------
  // Analog select decode: pins digital when both bits set
  // ----------------------------------------
  localparam logic [2:0] DIGITAL_CFG_MASK = 3'h6;

  // ----------------------------------------
  // AXI responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bps_pkg

// ---- bps_axil_slave.sv ----
// AXI4-Lite slave front end for the byte port registers
`timescale 1ns/1ps
module bps_axil_slave #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // Write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read address and data
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Register side
  output logic                   wr_en,
  output logic [7:0]             wr_idx,
  output logic [7:0]             wr_data,
  input  wire logic              wr_ok,
  output logic                   rd_en,
  output logic [7:0]             rd_idx,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_ok
);

  if (ADDR_W < 10) begin : g_addr_w_check
    $error("ADDR_W must reach index 8'h9F");
  end

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  idx;
    logic [7:0]  data;
    logic        lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bps_axi_st_t;

  bps_axi_st_t s;
  bps_axi_st_t next_s;
  logic        wr_fire;

  always_comb begin
    next_s = s;
    wr_fire = s.aw_got & s.w_got & ~s.bvalid;
    wr_en  = wr_fire & s.lane0;
    wr_idx = s.idx;
    wr_data = s.data;
    rd_en  = s_axi_arvalid & s.arready;
    rd_idx = s_axi_araddr[9:2];
    if (s_axi_awvalid & s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_got  = 1'b1;
      next_s.idx     = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid & s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_got  = 1'b1;
      next_s.data   = s_axi_wdata[7:0];
      next_s.lane0  = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_ok ? bps_pkg::RESP_OKAY : bps_pkg::RESP_SLVERR;
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
    end
    if (s.bvalid & s_axi_bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end
    if (rd_en) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = {24'h000000, rd_data};
      next_s.rresp   = rd_ok ? bps_pkg::RESP_OKAY : bps_pkg::RESP_SLVERR;
    end
    if (s.rvalid & s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // Byte lane 0 gates the store; the response goes out either way
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule : bps_axil_slave

// ---- bps_byte_port_asserts.sv ----
// Port-level assertions for the byte port block
`timescale 1ns/1ps
module bps_chk #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              reset_n,
  // Register bus
  input wire logic              s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  // Pins and event
  input wire logic [7:0]        data_pin_out,
  input wire logic [7:0]        data_pin_oe_n,
  input wire logic [2:0]        ctrl_pin_in,
  input wire logic [2:0]        ctrl_pin_out,
  input wire logic [2:0]        ctrl_pin_oe_n,
  input wire logic              slave_port_irq_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Read address of the answer in flight
  logic [ADDR_W-1:0] rd_addr;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) rd_addr <= '0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  property p_irq_cause;
    slave_port_irq_flag |-> $past(ctrl_pin_in, 2) inside {3'h0, 3'h1, 3'h2};
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("event without selected strobe");
  property p_irq_end;
    slave_port_irq_flag |-> !($past(ctrl_pin_in) inside {3'h0, 3'h1, 3'h2});
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("event before strobe end");
  property p_irq_pulse;
    slave_port_irq_flag |=> !slave_port_irq_flag;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("event longer than one cycle");
  property p_ctrl_src;
    $changed(ctrl_pin_oe_n) || $changed(ctrl_pin_out) |-> !$past(s_axi_awready);
  endproperty
  a_ctrl_src: assert property (p_ctrl_src) else $error("control pins changed without write");
  property p_dout_src;
    $changed(data_pin_out) |-> !$past(s_axi_awready);
  endproperty
  a_dout_src: assert property (p_dout_src) else $error("data out changed without write");
  property p_oe_cause;
    $changed(data_pin_oe_n) && $past(s_axi_awready)
      |-> $past(ctrl_pin_in) inside {3'h0, 3'h2} || $past(ctrl_pin_in, 2) inside {3'h0, 3'h2};
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("data enable moved without read");
  property p_rsv_bit;
    s_axi_rvalid && rd_addr[9:2] == bps_pkg::IDX_CTRL_DIR_ST |-> !s_axi_rdata[3];
  endproperty
  a_rsv_bit: assert property (p_rsv_bit) else $error("status bit 3 set");
  property p_ctrl_hi;
    s_axi_rvalid && rd_addr[9:2] == bps_pkg::IDX_CTRL_PORT |-> s_axi_rdata[7:3] == 5'h00;
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control port upper bits set");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == bps_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read with data");
endmodule : bps_chk

bind bps_byte_port bps_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clock, .reset_n, .s_axi_awready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .data_pin_out, .data_pin_oe_n, .ctrl_pin_in, .ctrl_pin_out,
  .ctrl_pin_oe_n, .slave_port_irq_flag
);

// ---- bps_host_bus.sv ----
// External processor bus model facing the byte port pins
`timescale 1ns/1ps
module bps_host_bus (
  // Clock
  input wire logic        clock,
  // Device pin drivers
  input wire logic [7:0]  data_pin_out,
  input wire logic [7:0]  data_pin_oe_n,
  input wire logic [2:0]  ctrl_pin_out,
  input wire logic [2:0]  ctrl_pin_oe_n,
  // Resolved pins
  output logic [7:0]      data_pin_in,
  output logic [2:0]      ctrl_pin_in
);
  logic [2:0] strobe_q = 3'h7;
  logic [7:0] bus_q = 8'h00;
  logic       drive_q = 1'b0;
  logic [7:0] noise_q = 8'h5A;
  // Undriven lines wander so a stale value never looks valid
  always_ff @(posedge clock) noise_q <= noise_q + 8'h3B;
  assign data_pin_in = (~data_pin_oe_n & data_pin_out) | (data_pin_oe_n & (drive_q ? bus_q : noise_q));
  assign ctrl_pin_in = (~ctrl_pin_oe_n & ctrl_pin_out) | (ctrl_pin_oe_n & strobe_q);
  task automatic hold(input logic on, input logic [7:0] v);
    bus_q <= v;
    drive_q <= on;
  endtask : hold
  task automatic ext_write(input logic [7:0] v, input int n, input logic sel_n);
    @(posedge clock);
    bus_q <= v;
    drive_q <= 1'b1;
    strobe_q <= {sel_n, 2'b01};
    repeat (n) @(posedge clock);
    strobe_q <= 3'h7;
    @(posedge clock);
    drive_q <= 1'b0;
    @(posedge clock);
  endtask : ext_write
  task automatic ext_read(output logic [7:0] v, input int n, input logic sel_n);
    @(posedge clock);
    strobe_q <= {sel_n, 2'b10};
    repeat (n + 1) @(posedge clock);
    v = data_pin_in;
    strobe_q <= 3'h7;
    repeat (2) @(posedge clock);
  endtask : ext_read
endmodule : bps_host_bus

// ---- tb_top.sv ----
// Self-checking bench for the byte port block
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] A_DP = {2'h0, bps_pkg::IDX_DATA_PORT, 2'h0};
  localparam logic [11:0] A_CP = {2'h0, bps_pkg::IDX_CTRL_PORT, 2'h0};
  localparam logic [11:0] A_DD = {2'h0, bps_pkg::IDX_DATA_DIR, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, bps_pkg::IDX_CTRL_DIR_ST, 2'h0};
  localparam logic [11:0] A_AC = {2'h0, bps_pkg::IDX_ANALOG_CFG, 2'h0};
  localparam logic [11:0] A_BAD = 12'h100;
  logic        clock = 1'b0, reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  data_pin_in, data_pin_out, data_pin_oe_n;
  logic [2:0]  ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe_n;
  logic        slave_port_irq_flag;
  int          mismatches = 0, cmp_count = 0, events = 0;
  int          seed = 32'h6723FC8D;
  initial begin
    forever #5 clock = ~clock;
  end
  bps_byte_port #(.ADDR_W(12)) uut (
    .clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .data_pin_in, .data_pin_out, .data_pin_oe_n, .ctrl_pin_in, .ctrl_pin_out, .ctrl_pin_oe_n,
    .slave_port_irq_flag
  );
  bps_host_bus u_host (
    .clock, .data_pin_out, .data_pin_oe_n, .ctrl_pin_out, .ctrl_pin_oe_n, .data_pin_in, .ctrl_pin_in
  );
  always @(posedge clock) begin
    if (slave_port_irq_flag === 1'b1) events++;
  end
  // ----
  // Expectations and bus tasks
  // ----
  function automatic logic [7:0] er(input logic [11:0] a);
    return {6'h0, (a == A_BAD) ? bps_pkg::RESP_SLVERR : bps_pkg::RESP_OKAY};
  endfunction : er
  function automatic logic [7:0] st(input logic ib, input logic ob, input logic ov);
    return {ib, ob, ov, 1'b1, 4'h7};
  endfunction : st
  function automatic logic [7:0] cpin(input logic [7:0] m, input logic [7:0] d, input logic [7:0] v);
    return (m[2:1] == 2'b11) ? {5'h0, d[2:0] | (~d[2:0] & v[2:0])} : 8'h00;
  endfunction : cpin
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic close_out(input logic hang);
    if (hang) mismatches++;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) close_out(1'b1);
    chk("bresp", er(a), {6'h0, s_axi_bresp});
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) close_out(1'b1);
    chk("rdata", e, s_axi_rdata[7:0]);
    chk("rresp", er(a), {6'h0, s_axi_rresp});
  endtask : rc
  // ----
  // Main sequence
  // ----
  initial begin
    logic [7:0] d, v, m;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rc(A_DD, 8'hFF);
    rc(A_ST, 8'h07);
    rc(A_AC, 8'h00);
    rc(A_CP, 8'h00);
    rc(A_BAD, 8'h00);
    wr(A_BAD, 8'h5A);
    chk("data_oe", 8'hFF, data_pin_oe_n);
    chk("ctrl_oe", 8'h07, {5'h0, ctrl_pin_oe_n});
    wr(A_ST, 8'hFF);
    rc(A_ST, 8'h37);
    wr(A_ST, 8'h00);
    rc(A_ST, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      m = 8'($random(seed));
      if (i[0]) m[2:1] = 2'b11;
      wr(A_AC, m);
      wr(A_ST, {5'h0, d[2:0]});
      wr(A_CP, v);
      rc(A_AC, {5'h0, m[2:0]});
      rc(A_CP, cpin(m, d, v));
      chk("ctrl_oe", {5'h0, d[2:0]}, {5'h0, ctrl_pin_oe_n});
    end
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      m = 8'($random(seed));
      u_host.hold(1'b1, m);
      wr(A_DD, d);
      wr(A_DP, v);
      rc(A_DP, (~d & v) | (d & m));
      chk("data_oe", d, data_pin_oe_n);
      chk("data_out", v, data_pin_out);
    end
    u_host.hold(1'b0, 8'h00);
    wr(A_AC, 8'h06);
    wr(A_ST, 8'h17);
    u_host.ext_write(8'($random(seed)), 1, 1'b0);
    rc(A_ST, st(1'b1, 1'b0, 1'b0));
    d = 8'($random(seed));
    u_host.ext_write(d, 3, 1'b0);
    u_host.ext_write(~d, 1, 1'b1);
    rc(A_ST, st(1'b1, 1'b0, 1'b1));
    rc(A_DP, d);
    rc(A_ST, st(1'b0, 1'b0, 1'b1));
    wr(A_ST, 8'h17);
    rc(A_ST, st(1'b0, 1'b0, 1'b0));
    v = 8'($random(seed));
    wr(A_DP, v);
    rc(A_ST, st(1'b0, 1'b1, 1'b0));
    chk("data_oe", 8'hFF, data_pin_oe_n);
    u_host.ext_read(m, 2, 1'b0);
    chk("ext_read", v, m);
    rc(A_ST, st(1'b0, 1'b0, 1'b0));
    wr(A_DP, v);
    u_host.ext_read(m, 1, 1'b1);
    rc(A_ST, st(1'b0, 1'b1, 1'b0));
    chk("events", 8'h03, 8'(events));
    wr(A_ST, 8'h37);
    wr(A_ST, 8'h27);
    rc(A_ST, 8'h27);
    s_axi_wstrb <= 4'hE;
    wr(A_ST, 8'h00);
    s_axi_wstrb <= 4'hF;
    rc(A_ST, 8'h27);
    close_out(1'b0);
  end
endmodule : tb_top
